// >>> src/cofc_pkg.sv
// Shared constants for the comparator output filter control block.
// Assumes a single bus clock and byte-wide registers on a 32-bit AXI4-Lite bus.
package cofc_pkg;

  // Printed register offsets are register indices; the byte address is four times the index.
  localparam logic [1:0] FILT_HYST_IDX   = 2'h0;
  localparam logic [1:0] MODE_CTRL_IDX   = 2'h1;
  localparam logic [3:0] FILT_HYST_ADDR  = {FILT_HYST_IDX, 2'b00};
  localparam logic [3:0] MODE_CTRL_ADDR  = {MODE_CTRL_IDX, 2'b00};

  // Field positions in the filter and hysteresis control register.
  localparam int         CNT_LSB         = 4;
  localparam int         CNT_MSB         = 6;
  localparam int         HYST_LSB        = 0;
  localparam int         HYST_MSB        = 1;
  localparam logic [7:0] FILT_HYST_WMASK = 8'h73;

  // Bit positions in the comparator mode control register.
  localparam int         SAMPLE_MODE_BIT = 7;
  localparam int         WINDOW_EN_BIT   = 6;
  localparam int         TRIG_MODE_BIT   = 5;
  localparam int         SPEED_BIT       = 4;
  localparam int         POL_FLIP_BIT    = 3;
  localparam int         OUT_SRC_BIT     = 2;
  localparam int         PIN_DRIVE_BIT   = 1;
  localparam int         MOD_EN_BIT      = 0;

  // Reset values of both registers.
  localparam logic [7:0] FILT_HYST_RST   = 8'h00;
  localparam logic [7:0] MODE_CTRL_RST   = 8'h00;

  // Bus clock cycles per filter sample when the divided bus clock is used.
  localparam logic [7:0] SAMPLE_DIV      = 8'h04;

  // Depth of the sample history, the largest programmable count.
  localparam int         HIST_DEPTH      = 7;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

endpackage

// >>> src/cofc_filter_if.sv
// Carrier between the control logic and the sample filter.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
interface cofc_filter_if;
  logic       sample_tick;  // One-cycle pulse: take one sample now.
  logic [2:0] sample_count; // Programmed count of agreeing samples.
  logic       sample_mode;  // Sample mode is on.
  logic       din;          // Windowed, unfiltered comparator value.
  logic       dout;         // Filtered comparator value.

  // Control side drives the settings and the data.
  modport ctl (output sample_tick, output sample_count, output sample_mode,
               output din, input dout);
  // Filter side answers with the filtered value.
  modport flt (input sample_tick, input sample_count, input sample_mode,
               input din, output dout);
endinterface

// >>> src/cofc_filter.sv
// Sample filter: accepts a new output state after N agreeing samples.
// Assumes the sample tick is already a clean one-cycle pulse on core_clk.
`timescale 1ns/1ps
module cofc_filter (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Link to the control logic.
  cofc_filter_if.flt fif
);

  logic [cofc_pkg::HIST_DEPTH-1:0] hist_r;   // Most recent sample in bit 0.
  logic [cofc_pkg::HIST_DEPTH-1:0] hist_nxt; // History with the new sample.
  logic [cofc_pkg::HIST_DEPTH-1:0] agree;    // Per-position agreement.
  logic                            all_agree;
  logic                            dout_r;
  logic                            dout_nxt;

  assign hist_nxt = {hist_r[cofc_pkg::HIST_DEPTH-2:0], fif.din};

  // Positions beyond the programmed count do not take part in the vote.
  genvar gi;
  generate
    for (gi = 0; gi < cofc_pkg::HIST_DEPTH; gi++) begin : g_agree
      assign agree[gi] = (3'(gi) >= fif.sample_count) || (hist_nxt[gi] == hist_nxt[0]);
    end
  endgenerate
  assign all_agree = &agree;

  // A zero count bypasses the filter or, in sample mode, forces a low output.
  assign dout_nxt = (fif.sample_count == 3'h0) ? (fif.sample_mode ? 1'b0 : fif.din) :
                    (fif.sample_tick && all_agree) ? hist_nxt[0] :
                    dout_r;

  // History shifts only on a sample tick, so the vote counts samples, not cycles.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_r <= '0;
      dout_r <= 1'b0;
    end else begin
      if (fif.sample_tick) begin
        hist_r <= hist_nxt;
      end
      dout_r <= dout_nxt;
    end
  end

  assign fif.dout = dout_r;

endmodule

// >>> src/cofc_top.sv
// Comparator output filter control: AXI4-Lite registers, input synchronisers,
// windowing, sample clock selection and the digital output filter.
// Assumes the raw comparator, window and sample inputs are asynchronous pins.
`timescale 1ns/1ps
module cofc_top (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // AXI4-Lite write address channel.
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  // AXI4-Lite write data channel.
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response channel.
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output wire logic [1:0]  s_axi_bresp,
  // AXI4-Lite read address channel.
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  // AXI4-Lite read data channel.
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  // Asynchronous inputs from the analog side and the pins.
  input  wire logic        cmp_raw_in,
  input  wire logic        window_in,
  input  wire logic        sample_in,
  // Settings driven to the analog comparator and the system.
  output wire logic [1:0]  hysteresis_level,
  output wire logic        speed_select,
  output wire logic        timer_trigger_mode,
  output wire logic        module_enable,
  output wire logic        output_pin_drive,
  // Comparator results.
  output wire logic        windowed_raw_output,
  output wire logic        filtered_output,
  output wire logic        comparator_out
);

  // Address decode; bit 2 flags a miss.
  function automatic logic [2:0] reg_decode(input logic [3:0] addr);
    reg_decode = 3'b100;
    if (addr == cofc_pkg::FILT_HYST_ADDR) begin
      reg_decode = 3'b001;
    end else if (addr == cofc_pkg::MODE_CTRL_ADDR) begin
      reg_decode = 3'b010;
    end
  endfunction

  // Register storage.
  logic [7:0]  filt_hyst_r;      // Filter count and hysteresis level.
  logic [7:0]  mode_ctrl_r;      // Mode and enable bits.
  logic [7:0]  filt_hyst_nxt;
  logic [7:0]  mode_ctrl_nxt;

  // Write path state.
  logic        aw_hold_r;        // A write address has been taken.
  logic        w_hold_r;         // Write data have been taken.
  logic [3:0]  awaddr_r;         // Held write address.
  logic [7:0]  wdata_r;          // Held low byte of the write data.
  logic        wstrb0_r;         // Held strobe of byte lane 0.
  logic        bvalid_r;         // Write response pending.
  logic [1:0]  bresp_r;          // Write response code.
  logic        do_write;         // Both halves present and response slot free.
  logic [2:0]  wsel;             // Decoded write target.

  // Read path state.
  logic        rvalid_r;         // Read data pending.
  logic [31:0] rdata_r;          // Read data held for the master.
  logic [1:0]  rresp_r;          // Read response code.
  logic        ar_take;          // Read address accepted this cycle.
  logic [2:0]  rsel;             // Decoded read target.
  logic [7:0]  rbyte;            // Selected register value.

  // Synchronisers: bit 0 raw comparator, bit 1 window, bit 2 external sample.
  logic [2:0]  async_in;
  logic [2:0]  sync1_r;          // First stage, read only by the second stage.
  logic [2:0]  sync2_r;
  logic [2:0]  sync3_r;
  logic [2:0]  clean_r;          // Accepted level after two stages agree.

  // Sample clock generation.
  logic [7:0]  div_cnt_r;        // Bus clock divider.
  logic        div_tick;         // One-cycle pulse from the divider.
  logic        samp_prev_r;      // Previous clean sample level.
  logic        samp_rise;        // Rising edge of the external sample.

  // Comparator data path.
  logic        cmp_pol;          // Comparator after the polarity choice.
  logic        win_r;            // Windowed, unfiltered value.
  logic        win_nxt;
  logic        cmp_out_r;        // Selected comparator output.

  // Field views of the registers.
  logic        sample_mode;
  logic        window_en;
  logic        polarity_flip;
  logic        output_source_select;
  logic [2:0]  filter_sample_count;

  cofc_filter_if fif ();

  assign filter_sample_count  = filt_hyst_r[cofc_pkg::CNT_MSB:cofc_pkg::CNT_LSB];
  assign sample_mode          = mode_ctrl_r[cofc_pkg::SAMPLE_MODE_BIT];
  assign window_en            = mode_ctrl_r[cofc_pkg::WINDOW_EN_BIT];
  assign polarity_flip        = mode_ctrl_r[cofc_pkg::POL_FLIP_BIT];
  assign output_source_select = mode_ctrl_r[cofc_pkg::OUT_SRC_BIT];

  // ---- Write channel ----

  // Address and data are taken independently and held until written.
  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready  = !w_hold_r;
  assign do_write      = aw_hold_r && w_hold_r && !bvalid_r;
  assign wsel          = reg_decode(awaddr_r);

  // Reserved positions are masked out so they never store a one.
  assign filt_hyst_nxt = (do_write && wsel[0] && wstrb0_r) ?
                         (wdata_r & cofc_pkg::FILT_HYST_WMASK) : filt_hyst_r;
  assign mode_ctrl_nxt = (do_write && wsel[1] && wstrb0_r) ? wdata_r : mode_ctrl_r;

  // Capture of the write address.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_r <= 1'b0;
    end
  end

  // Capture of the write data; only byte lane 0 carries register bits.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_hold_r <= 1'b0;
      wdata_r  <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r  <= s_axi_wdata[7:0];
      wstrb0_r <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_hold_r <= 1'b0;
    end
  end

  // Write response; a miss gets a slave error.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= cofc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wsel[2] ? cofc_pkg::RESP_SLVERR : cofc_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Register update; both registers clear to zero on reset.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_hyst_r <= cofc_pkg::FILT_HYST_RST;
      mode_ctrl_r <= cofc_pkg::MODE_CTRL_RST;
    end else begin
      filt_hyst_r <= filt_hyst_nxt;
      mode_ctrl_r <= mode_ctrl_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ---- Read channel ----

  // One read at a time.
  assign s_axi_arready = !rvalid_r;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rsel          = reg_decode(s_axi_araddr);
  assign rbyte         = rsel[0] ? (filt_hyst_r & cofc_pkg::FILT_HYST_WMASK) :
                         rsel[1] ? mode_ctrl_r : 8'h00;

  // Read data are registered so they stay stable while rvalid waits.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= cofc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rbyte};
      rresp_r  <= rsel[2] ? cofc_pkg::RESP_SLVERR : cofc_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ---- Input synchronisers ----

  assign async_in = {sample_in, window_in, cmp_raw_in};

  // Three stages per pin; a change counts only when stages two and three agree,
  // which also rejects a single-cycle glitch at the cost of a cycle of delay.
  genvar si;
  generate
    for (si = 0; si < 3; si++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_r[si] <= 1'b0;
          sync2_r[si] <= 1'b0;
          sync3_r[si] <= 1'b0;
          clean_r[si] <= 1'b0;
        end else begin
          sync1_r[si] <= async_in[si];
          sync2_r[si] <= sync1_r[si];
          sync3_r[si] <= sync2_r[si];
          if (sync2_r[si] == sync3_r[si]) begin
            clean_r[si] <= sync2_r[si];
          end
        end
      end
    end
  endgenerate

  // ---- Sample clock selection ----

  assign div_tick  = (div_cnt_r == 8'h00);
  assign samp_rise = clean_r[2] && !samp_prev_r;

  // Divider for the bus clock based sample rate, plus edge memory for the pin.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_r   <= 8'h00;
      samp_prev_r <= 1'b0;
    end else begin
      div_cnt_r   <= div_tick ? (cofc_pkg::SAMPLE_DIV - 8'h01) : (div_cnt_r - 8'h01);
      samp_prev_r <= clean_r[2];
    end
  end

  // Sample mode takes its ticks from the pin, otherwise from the divider;
  // the pin path is resynchronised, so a tick comes four clocks after a pin rise.
  assign fif.sample_tick  = sample_mode ? samp_rise : div_tick;
  assign fif.sample_count = filter_sample_count;
  assign fif.sample_mode  = sample_mode;

  // ---- Windowing and filtering ----

  assign cmp_pol = clean_r[0] ^ polarity_flip;

  // With windowing on, the value is sampled only while the window is open.
  // Windowing and sample mode together are not meant to be used.
  assign win_nxt = (!window_en || clean_r[1]) ? cmp_pol : win_r;

  // Windowed value register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_r <= 1'b0;
    end else begin
      win_r <= win_nxt;
    end
  end

  assign fif.din = win_r;

  cofc_filter u_filter (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .fif      (fif)
  );

  // Output selection; a disabled module holds its output low.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_out_r <= 1'b0;
    end else begin
      cmp_out_r <= mode_ctrl_r[cofc_pkg::MOD_EN_BIT] &&
                   (output_source_select ? win_r : fif.dout);
    end
  end

  // ---- Settings to the analog side ----

  assign hysteresis_level    = filt_hyst_r[cofc_pkg::HYST_MSB:cofc_pkg::HYST_LSB];
  assign speed_select        = mode_ctrl_r[cofc_pkg::SPEED_BIT];
  assign timer_trigger_mode  = mode_ctrl_r[cofc_pkg::TRIG_MODE_BIT];
  assign module_enable       = mode_ctrl_r[cofc_pkg::MOD_EN_BIT];
  assign output_pin_drive    = mode_ctrl_r[cofc_pkg::PIN_DRIVE_BIT];
  assign windowed_raw_output = win_r;
  assign filtered_output     = fif.dout;
  assign comparator_out      = cmp_out_r;

endmodule

// >>> test/cofc_top_monitor.sv
// Concurrent checks on the ports of the comparator output filter control block.
// Assumes a bind into cofc_top and one bus transfer at a time from the bench.
`timescale 1ns/1ps
module cofc_top_monitor (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Register bus.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Settings and results.
  input wire logic [1:0]  hysteresis_level,
  input wire logic        speed_select,
  input wire logic        timer_trigger_mode,
  input wire logic        module_enable,
  input wire logic        output_pin_drive,
  input wire logic        windowed_raw_output,
  input wire logic        filtered_output,
  input wire logic        comparator_out
);
  wire logic aw_take = s_axi_awvalid && s_axi_awready; // Write address accepted.
  wire logic w_take  = s_axi_wvalid && s_axi_wready;   // Write data accepted.
  logic [3:0] aw_addr_r, rd_addr_r;                    // Last write and read addresses.
  logic [7:0] w_data_r;                                // Last accepted write byte.
  logic       w_strb_r, aw_ok_r, w_ok_r;               // Held strobe and pending halves of a write.
  logic [2:0] cnt_s_r;                                 // Shadow of the sample count.
  logic       se_s_r;                                  // Shadow of sample mode.

  // Captures carry no reset: they are only read after a transfer set them.
  always_ff @(posedge core_clk) begin
    if (aw_take) aw_addr_r <= s_axi_awaddr;
    if (w_take) w_data_r <= s_axi_wdata[7:0];
    if (w_take) w_strb_r <= s_axi_wstrb[0];
    if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
  end

  // Shadow updates one edge after the later half.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_ok_r <= 1'h0;
      w_ok_r  <= 1'h0;
      cnt_s_r <= 3'h0;
      se_s_r  <= 1'h0;
    end else if (aw_ok_r && w_ok_r) begin
      aw_ok_r <= 1'h0;
      w_ok_r  <= 1'h0;
      if (w_strb_r && aw_addr_r == cofc_pkg::FILT_HYST_ADDR) cnt_s_r <= w_data_r[6:4];
      if (w_strb_r && aw_addr_r == cofc_pkg::MODE_CTRL_ADDR) se_s_r <= w_data_r[7];
    end else begin
      if (aw_take) aw_ok_r <= 1'h1;
      if (w_take) w_ok_r <= 1'h1;
    end
  end

  wire logic rd0 = s_axi_rvalid && rd_addr_r == cofc_pkg::FILT_HYST_ADDR; // Read of reg 0.
  wire logic rd1 = s_axi_rvalid && rd_addr_r == cofc_pkg::MODE_CTRL_ADDR; // Read of reg 1.
  wire logic mapped = aw_addr_r == cofc_pkg::FILT_HYST_ADDR
                   || aw_addr_r == cofc_pkg::MODE_CTRL_ADDR;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before acceptance");
  a_resv_zero: assert property (rd0 |-> s_axi_rdata[31:7] == 25'h0 && s_axi_rdata[3:2] == 2'h0)
    else $error("reserved bits read nonzero");
  a_hyst_read: assert property (rd0 |-> s_axi_rdata[1:0] == hysteresis_level)
    else $error("hysteresis output differs from register");
  a_mode_read: assert property (rd1 |-> {s_axi_rdata[5:4], s_axi_rdata[1:0]} ==
    {timer_trigger_mode, speed_select, output_pin_drive, module_enable})
    else $error("mode outputs differ from register");
  a_unmapped_read: assert property (s_axi_rvalid && !rd0 && !rd1 |->
    s_axi_rresp == cofc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_bresp_map: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (mapped ? cofc_pkg::RESP_OKAY : cofc_pkg::RESP_SLVERR))
    else $error("write response code wrong");
  a_zero_cnt_low: assert property ((cnt_s_r == 3'h0 && se_s_r) [*4] |-> !filtered_output)
    else $error("filtered output not low");
  a_bypass_follow: assert property ((cnt_s_r == 3'h0 && !se_s_r) [*4] |->
    filtered_output == $past(windowed_raw_output))
    else $error("filtered output does not follow windowed value");
  a_out_disabled: assert property (!module_enable [*2] |-> !comparator_out)
    else $error("comparator output active while disabled");

  // Main scenarios reached.
  c_unmapped: cover property ($rose(s_axi_bvalid) && s_axi_bresp == cofc_pkg::RESP_SLVERR);
  c_cnt_seven: cover property (cnt_s_r == 3'h7 && $rose(filtered_output));
  c_out_high: cover property ($rose(comparator_out));
endmodule

bind cofc_top cofc_top_monitor mon (.*);

// >>> test/testbench.sv
// Self-checking bench for the comparator output filter control block.
// Assumes cofc_top with its checker bound; the bench drives every input.
`timescale 1ns/1ps
module testbench;
  localparam int DIV = int'(cofc_pkg::SAMPLE_DIV); // Cycles between filter samples.
  logic        core_clk = 1'h0, reset_n = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, rd, d;
  logic        cmp_raw_in = 1'h0, window_in = 1'h0, sample_in = 1'h0;
  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp, hysteresis_level;
  wire logic [31:0] s_axi_rdata;
  wire logic        speed_select, timer_trigger_mode, module_enable, output_pin_drive;
  wire logic        windowed_raw_output, filtered_output, comparator_out;
  logic [1:0]  resp;
  int          error_cnt = 0, n_compared = 0, len;
  int unsigned seed_v;

  // Bus clock, 4 ns period.
  always #2 core_clk = ~core_clk;

  cofc_top uut (.*);

  // Compare of data words and single bits.
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Compare of bus response codes.
  task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    check_val(what, {30'h0, exp}, {30'h0, got});
  endtask

  // The single place where the run ends.
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Readback of the first register: only count and hysteresis survive.
  function automatic logic [31:0] exp_reg0(input logic [31:0] v);
    return {25'h0, v[6:4], 2'h0, v[1:0]};
  endfunction

  // A pulse passes only if enough samples agree.
  function automatic logic exp_seen(input int n, input int l);
    return (n == 0) ? (l > 0) : (l >= DIV * n + DIV);
  endfunction

  // Write: both halves offered together, each released when taken.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                           output logic [1:0] r);
    bit aw_d = 0, w_d = 0;
    int n = 0;
    @(posedge core_clk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'h1;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'h1;
    while (!(aw_d && w_d) && n < 100) begin
      @(posedge core_clk);
      n++;
      if (!aw_d && s_axi_awready) begin
        aw_d = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_d && s_axi_wready) begin
        w_d = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    // Ready stands until a response is seen.
    while (!s_axi_bvalid && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 100) check_val("write handshake", 32'h0, 32'h1);
  endtask

  // Read: address held until taken, ready held until data arrives.
  task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!s_axi_arready && n < 100);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 100) check_val("read handshake", 32'h0, 32'h1);
  endtask

  // Drives a comparator pulse; watches for a filtered rise.
  task automatic pulse_check(input int n, input int l);
    bit seen = 0;
    @(posedge core_clk);
    cmp_raw_in <= 1'h1;
    for (int i = 0; i < l + DIV * n + 40; i++) begin
      @(posedge core_clk);
      if (i == l - 1) cmp_raw_in <= 1'h0;
      if (filtered_output === 1'h1) seen = 1;
    end
    check_val("filtered pulse", {31'h0, exp_seen(n, l)}, {31'h0, seen});
    check_val("filtered idle", 32'h0, {31'h0, filtered_output});
  endtask

  // Cuts a hang short.
  initial begin
    #200000;
    $display("unexpected run length: expected finish, seen timeout");
    error_cnt++;
    report_and_stop();
  end

  initial begin
    seed_v = $urandom(32'hc721ebf1);
    repeat (4) @(posedge core_clk);
    reset_n <= 1'h1;
    // Reset values of both registers.
    axi_read(4'h0, rd, resp);
    check_val("reg0 reset", 32'h0, rd);
    axi_read(4'h4, rd, resp);
    check_val("reg1 reset", 32'h0, rd);
    $display("test reset_values done");
    // Random register traffic.
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      axi_write(4'h0, d, 4'hf, resp);
      axi_read(4'h0, rd, resp);
      check_val("reg0 readback", exp_reg0(d), rd);
      check_val("hysteresis", {30'h0, d[1:0]}, {30'h0, hysteresis_level});
      d[7] = d[7] & (|d[6:4]);
      d[6] = d[6] & ~d[7];
      axi_write(4'h4, d, 4'h1, resp);
      axi_read(4'h4, rd, resp);
      check_val("reg1 readback", {24'h0, d[7:0]}, rd);
    end
    axi_write(4'h4, ~d, 4'h0, resp);
    check_resp("masked write resp", cofc_pkg::RESP_OKAY, resp);
    axi_read(4'h4, rd, resp);
    check_val("masked write", {24'h0, d[7:0]}, rd);
    axi_write(4'h8, 32'hff, 4'hf, resp);
    check_resp("unmapped write", cofc_pkg::RESP_SLVERR, resp);
    axi_read(4'hc, rd, resp);
    check_resp("unmapped read", cofc_pkg::RESP_SLVERR, resp);
    check_val("unmapped data", 32'h0, rd);
    $display("test registers done");
    // Every count: long pulses pass; from count 2 up, short ones are held back.
    axi_write(4'h4, 32'h0, 4'h1, resp);
    for (int n = 0; n < 8; n++) begin
      axi_write(4'h0, {25'h0, n[2:0], 4'h0}, 4'h1, resp);
      repeat (40) @(posedge core_clk);
      // The synchroniser swallows one-cycle pulses, so bypass pulses last two or more.
      len = (n == 0) ? 2 + $urandom % 3 : DIV * n + DIV + $urandom % 8;
      pulse_check(n, len);
      if (n >= 2) pulse_check(n, DIV * (n - 1));
    end
    $display("test filter_counts done");
    // Sample mode: only the sample pin clocks the filter.
    axi_write(4'h0, 32'h20, 4'h1, resp);
    axi_write(4'h4, 32'h80, 4'h1, resp);
    cmp_raw_in <= 1'h1;
    repeat (40) @(posedge core_clk);
    check_val("no sample edges", 32'h0, {31'h0, filtered_output});
    repeat (2) begin
      sample_in <= 1'h1;
      repeat (4) @(posedge core_clk);
      sample_in <= 1'h0;
      repeat (4) @(posedge core_clk);
    end
    repeat (10) @(posedge core_clk);
    check_val("two sample edges", 32'h1, {31'h0, filtered_output});
    axi_write(4'h0, 32'h0, 4'h1, resp);
    repeat (8) @(posedge core_clk);
    check_val("zero count sampled", 32'h0, {31'h0, filtered_output});
    axi_write(4'h4, 32'h0, 4'h1, resp);
    repeat (8) @(posedge core_clk);
    check_val("zero count bypass", 32'h1, {31'h0, filtered_output});
    $display("test sample_mode done");
    // Window, polarity and output select.
    axi_write(4'h4, 32'h45, 4'h1, resp);
    cmp_raw_in <= 1'h0;
    repeat (10) @(posedge core_clk);
    check_val("window closed", 32'h1, {31'h0, windowed_raw_output});
    window_in <= 1'h1;
    repeat (10) @(posedge core_clk);
    check_val("window open", 32'h0, {31'h0, windowed_raw_output});
    axi_write(4'h4, 32'h4d, 4'h1, resp);
    repeat (10) @(posedge core_clk);
    check_val("flipped output", 32'h1, {31'h0, comparator_out});
    axi_write(4'h4, 32'h4c, 4'h1, resp);
    repeat (4) @(posedge core_clk);
    check_val("disabled output", 32'h0, {31'h0, comparator_out});
    $display("test output_path done");
    report_and_stop();
  end
endmodule
